/* File: hdl/aad_core.sv */
// operand addressing, arithmetic group and branch targets
`timescale 1ns/1ps
`include "aad_map.svh"
module aad_core #(
  parameter int RAM_DEPTH = `AAD_RAM_DEPTH
) (
  input  wire logic              ref_clk_in,
  input  wire logic              nrst_in,
  input  wire logic              op_valid_in,
  output logic                   ready_out,
  input  aad_pkg::aad_op_t       op_code_in,
  input  aad_pkg::aad_src_t      src_mode_in,
  input  wire logic [2:0]        work_reg_sel_in,
  input  wire logic              pointer_reg_indirect_in,
  input  wire logic [7:0]        direct_addr_in,
  input  wire logic [7:0]        imm_byte_in,
  input  wire logic [15:0]       imm_word_in,
  input  wire logic [15:0]       next_pc_in,
  input  wire logic [10:0]       page_local_target_in,
  input  wire logic [15:0]       long_target_in,
  input  wire logic [7:0]        rel_offset_in,
  output logic                   sfr_rd_out,
  output logic                   sfr_wr_out,
  output logic [7:0]             sfr_addr_out,
  output logic [7:0]             sfr_wr_data_out,
  input  wire logic [7:0]        sfr_rd_data_in,
  output logic                   done_out,
  output logic [7:0]             acc_out,
  output logic [7:0]             aux_out,
  output logic [7:0]             psw_out,
  output logic [15:0]            sixteen_bit_pointer_out,
  output logic                   target_valid_out,
  output logic [15:0]            target_pc_out,
  output logic                   bit_value_out
);
  import aad_pkg::*;

  initial begin
    if (RAM_DEPTH != 128) $error("aad_core: lower RAM must hold 128 bytes");
  end

  aad_state_t state_r;
  aad_op_t    op_r;
  aad_src_t   src_r;
  logic [7:0]  acc_r, aux_r, psw_r, opnd_r, imm_r, loc_r, res_r, rel_r;
  logic [15:0] ptr16_r, pc_r, word_r, target_r;
  logic [10:0] page_r;
  logic [2:0]  bitpos_r;
  logic        wr_pend_r, target_valid_r, bit_r;
  logic [6:0]  ram_rd_addr;
  logic [7:0]  ram_rd_data;
  logic        ram_wr_en;
  logic [7:0]  src_val, acc_nxt, aux_nxt, res_nxt, flags_nxt, psw_nxt;
  logic [10:0] as_out;
  logic [15:0] prod, ptr_nxt;
  logic [8:0]  bcd_lo, bcd_hi;
  logic        bcd_cy, wr_nxt;

  function automatic logic [6:0] reg_addr(input logic [7:0] psw, input logic [2:0] idx);
    return {2'b00, psw[`AAD_PSW_RS1], psw[`AAD_PSW_RS0], idx};
  endfunction : reg_addr

  function automatic logic is_local_sfr(input logic [7:0] a);
    return a == `AAD_SFR_ACC || a == `AAD_SFR_AUX || a == `AAD_SFR_PSW ||
           a == `AAD_SFR_PTR_LO || a == `AAD_SFR_PTR_HI;
  endfunction : is_local_sfr

  function automatic logic [10:0] add_sub(input logic [7:0] a, input logic [7:0] b,
                                          input logic ci, input logic sub);
    logic [7:0] bb;
    logic       c;
    logic [4:0] lo;
    logic [8:0] full;
    bb   = sub ? ~b : b;
    c    = sub ? ~ci : ci;
    lo   = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, c};
    full = {1'b0, a} + {1'b0, bb} + {8'h00, c};
    return {full[8] ^ sub, lo[4] ^ sub, (a[7] == bb[7]) && (full[7] != a[7]), full[7:0]};
  endfunction : add_sub

  assign ready_out = (state_r == st_idle);
  assign done_out  = (state_r == st_wb);

  // address for the RAM read: register, pointer register, direct or bit byte
  always_comb begin
    ram_rd_addr = loc_r[6:0];
    if (state_r == st_idle) begin
      if (op_code_in == op_bit_read)
        ram_rd_addr = {3'(`AAD_BIT_BASE), direct_addr_in[6:3]}; // [RULE6]
      else if (src_mode_in == src_reg)
        ram_rd_addr = reg_addr(psw_r, work_reg_sel_in); // [RULE1]
      else if (src_mode_in == src_indirect)
        ram_rd_addr = reg_addr(psw_r, {2'b00, pointer_reg_indirect_in}); // [RULE3]
      else
        ram_rd_addr = direct_addr_in[6:0]; // [RULE2]
    end else if (state_r == st_ptr) begin
      ram_rd_addr = ram_rd_data[6:0]; // [RULE3]
    end
  end

  aad_ram #(.DEPTH(RAM_DEPTH), .WIDTH(8)) u_ram (
    .ref_clk_in (ref_clk_in),
    .rd_addr_in (ram_rd_addr),
    .rd_data_out(ram_rd_data),
    .wr_en_in   (ram_wr_en),
    .wr_addr_in (loc_r[6:0]),
    .wr_data_in (res_r)
  );

  // every direct byte above 0x7f is a special register; upper RAM is absent
  assign ram_wr_en       = done_out && wr_pend_r && !loc_r[7];
  assign sfr_wr_out      = done_out && wr_pend_r && loc_r[7] && !is_local_sfr(loc_r);
  assign sfr_rd_out      = (state_r == st_read) && loc_r[7] && !is_local_sfr(loc_r);
  assign sfr_addr_out    = loc_r;
  assign sfr_wr_data_out = res_r;

  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      state_r <= st_idle;
    end else begin
      case (state_r)
        st_idle: if (op_valid_in) begin
          if (op_code_in == op_bit_read || src_mode_in == src_reg || src_mode_in == src_direct)
            state_r <= st_read;
          else if (src_mode_in == src_indirect)
            state_r <= st_ptr;
          else
            state_r <= st_exec;
        end
        st_ptr:  state_r <= st_read;
        st_read: state_r <= st_exec;
        st_exec: state_r <= st_wb;
        st_wb:   state_r <= st_idle;
        default: state_r <= st_idle;
      endcase
    end
  end

  // capture of the decoded instruction and the operand location
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      op_r     <= op_nop;
      src_r    <= src_none;
      imm_r    <= 8'h00;
      word_r   <= 16'h0000;
      pc_r     <= `AAD_RST_PC;
      page_r   <= 11'h000;
      rel_r    <= 8'h00;
      bitpos_r <= 3'h0;
      loc_r    <= 8'h00;
    end else if (state_r == st_idle && op_valid_in) begin
      op_r     <= op_code_in;
      src_r    <= src_mode_in;
      imm_r    <= imm_byte_in; // [RULE4]
      word_r   <= op_code_in == op_jmp_long ? long_target_in : imm_word_in;
      pc_r     <= next_pc_in;
      page_r   <= page_local_target_in;
      rel_r    <= rel_offset_in;
      bitpos_r <= direct_addr_in[2:0];
      if (op_code_in == op_bit_read)
        loc_r <= direct_addr_in[7] ? {direct_addr_in[7:3], 3'h0}
                                   : {1'b0, ram_rd_addr}; // [RULE6]
      else if (src_mode_in == src_reg)
        loc_r <= {1'b0, ram_rd_addr};
      else
        loc_r <= direct_addr_in;
    end else if (state_r == st_ptr) begin
      loc_r <= {1'b0, ram_rd_data[6:0]};
    end
  end

  // operand value: RAM, local special register or the outside special bus
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      opnd_r <= 8'h00;
    end else if (state_r == st_read) begin
      if (!loc_r[7])
        opnd_r <= ram_rd_data;
      else if (loc_r == `AAD_SFR_ACC)
        opnd_r <= acc_r;
      else if (loc_r == `AAD_SFR_AUX)
        opnd_r <= aux_r;
      else if (loc_r == `AAD_SFR_PSW)
        opnd_r <= {psw_r[7:1], ^acc_r};
      else if (loc_r == `AAD_SFR_PTR_LO)
        opnd_r <= ptr16_r[7:0];
      else if (loc_r == `AAD_SFR_PTR_HI)
        opnd_r <= ptr16_r[15:8];
      else
        opnd_r <= sfr_rd_data_in;
    end
  end

  assign src_val = src_r == src_imm ? imm_r : src_r == src_acc ? acc_r : opnd_r;
  assign as_out  = add_sub(acc_r, src_val,
                           op_r != op_add && psw_r[`AAD_PSW_CY], op_r == subtract_borrow_op);
  assign prod    = acc_r * aux_r;
  assign bcd_lo  = (acc_r[3:0] > `AAD_BCD_LIMIT || psw_r[`AAD_PSW_AC]) ?
                   {1'b0, acc_r} + `AAD_BCD_LO : {1'b0, acc_r};
  assign bcd_cy  = psw_r[`AAD_PSW_CY] | bcd_lo[8];
  assign bcd_hi  = (bcd_lo[7:4] > `AAD_BCD_LIMIT || bcd_cy) ?
                   {1'b0, bcd_lo[7:0]} + `AAD_BCD_HI : {1'b0, bcd_lo[7:0]};

  // arithmetic results for the execute cycle
  always_comb begin
    acc_nxt   = acc_r;
    aux_nxt   = aux_r;
    res_nxt   = src_val;
    flags_nxt = psw_r;
    ptr_nxt   = ptr16_r;
    wr_nxt    = 1'b0;
    case (op_r)
      op_add, sum_with_carry_op, subtract_borrow_op: begin
        acc_nxt = as_out[7:0]; // [RULE10] [RULE11] [RULE12]
        flags_nxt[`AAD_PSW_CY] = as_out[10]; // [RULE17]
        flags_nxt[`AAD_PSW_AC] = as_out[9];
        flags_nxt[`AAD_PSW_OV] = as_out[8];
      end
      op_inc, minus_one_op: begin
        res_nxt = op_r == op_inc ? src_val + 8'h01 : src_val - 8'h01; // [RULE13] [RULE14]
        if (src_r == src_acc) acc_nxt = res_nxt;
        else wr_nxt = 1'b1;
      end
      op_inc_ptr:  ptr_nxt = ptr16_r + 16'h0001; // [RULE13]
      op_load_ptr: ptr_nxt = word_r; // [RULE5]
      product_op: begin
        acc_nxt = prod[7:0]; // [RULE16]
        aux_nxt = prod[15:8];
        flags_nxt[`AAD_PSW_CY] = 1'b0;
        flags_nxt[`AAD_PSW_OV] = prod[15:8] != 8'h00;
      end
      op_quotient: begin
        // divide by zero keeps both operands and flags it in overflow
        flags_nxt[`AAD_PSW_CY] = 1'b0;
        flags_nxt[`AAD_PSW_OV] = aux_r == 8'h00;
        if (aux_r != 8'h00) begin
          acc_nxt = acc_r / aux_r; // [RULE16]
          aux_nxt = acc_r % aux_r;
        end
      end
      bcd_adjust_op: begin
        acc_nxt = bcd_hi[7:0]; // [RULE15]
        flags_nxt[`AAD_PSW_CY] = bcd_cy | bcd_hi[8];
      end
      default: ;
    endcase
  end

  assign psw_nxt = {res_r[7:1], 1'b0};

  // architectural state: execute updates, then the write-back of a local register
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      acc_r     <= `AAD_RST_ACC;
      aux_r     <= 8'h00;
      psw_r     <= `AAD_RST_PSW;
      ptr16_r   <= `AAD_RST_PTR;
      res_r     <= 8'h00;
      wr_pend_r <= 1'b0;
    end else if (state_r == st_exec) begin
      acc_r     <= acc_nxt;
      aux_r     <= aux_nxt;
      psw_r     <= flags_nxt;
      ptr16_r   <= ptr_nxt;
      res_r     <= res_nxt;
      wr_pend_r <= wr_nxt;
    end else if (done_out && wr_pend_r) begin
      wr_pend_r <= 1'b0;
      if (loc_r == `AAD_SFR_ACC) acc_r <= res_r;
      if (loc_r == `AAD_SFR_AUX) aux_r <= res_r;
      if (loc_r == `AAD_SFR_PSW) psw_r <= psw_nxt;
      if (loc_r == `AAD_SFR_PTR_LO) ptr16_r[7:0] <= res_r;
      if (loc_r == `AAD_SFR_PTR_HI) ptr16_r[15:8] <= res_r;
    end
  end

  // branch targets and bit reads
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      target_r       <= `AAD_RST_PC;
      target_valid_r <= 1'b0;
      bit_r          <= 1'b0;
    end else begin
      target_valid_r <= 1'b0;
      if (state_r == st_exec) begin
        case (op_r)
          op_jmp_long: begin
            target_r       <= word_r; // [RULE7]
            target_valid_r <= 1'b1;
          end
          op_jmp_page: begin
            target_r       <= {pc_r[15:11], page_r}; // [RULE8]
            target_valid_r <= 1'b1;
          end
          op_jmp_rel: begin
            target_r       <= pc_r + {{8{rel_r[7]}}, rel_r}; // [RULE9]
            target_valid_r <= 1'b1;
          end
          op_bit_read: bit_r <= opnd_r[bitpos_r]; // [RULE6]
          default: ;
        endcase
      end
    end
  end

  assign acc_out                 = acc_r;
  assign aux_out                 = aux_r;
  assign psw_out                 = {psw_r[7:1], ^acc_r};
  assign sixteen_bit_pointer_out = ptr16_r;
  assign target_valid_out        = target_valid_r;
  assign target_pc_out           = target_r;
  assign bit_value_out           = bit_r;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence take_s(aad_op_t o, aad_src_t s);
    state_r == st_idle && op_valid_in && op_code_in == o && src_mode_in == s;
  endsequence
  sequence take_op_s(aad_op_t o);
    state_r == st_idle && op_valid_in && op_code_in == o;
  endsequence

  bank_register_pick_a: assert property ( // [RULE1]
    take_s(op_add, src_reg) |->
      ram_rd_addr == {2'b00, psw_r[4:3], work_reg_sel_in})
    else $error("register operand outside active bank");
  indirect_source_a: assert property ( // [RULE3]
    take_s(minus_one_op, src_indirect) |=>
      state_r == st_ptr ##1 loc_r == {1'b0, $past(ram_rd_data[6:0])})
    else $error("indirect address not taken from pointer register");
  imm_add_result_a: assert property ( // [RULE10]
    take_s(op_add, src_imm) |-> ##2 acc_r == 8'($past(acc_r, 2) + $past(imm_byte_in, 2)))
    else $error("add immediate result wrong");
  carry_add_result_a: assert property ( // [RULE11]
    take_s(sum_with_carry_op, src_imm) |-> ##2
      acc_r == 8'($past(acc_r, 2) + $past(imm_byte_in, 2) + {7'h00, $past(psw_r[7], 2)}))
    else $error("add with carry result wrong");
  borrow_sub_result_a: assert property ( // [RULE12]
    take_s(subtract_borrow_op, src_imm) |-> ##2
      acc_r == 8'($past(acc_r, 2) - $past(imm_byte_in, 2) - {7'h00, $past(psw_r[7], 2)}))
    else $error("subtract with borrow result wrong");
  incdec_flags_kept_a: assert property ( // [RULE17]
    state_r == st_exec && (op_r == op_inc || op_r == minus_one_op) |=>
      psw_r[7:6] == $past(psw_r[7:6]) && psw_r[2] == $past(psw_r[2]))
    else $error("increment or decrement changed flags");
  pointer_increment_a: assert property ( // [RULE13]
    take_op_s(op_inc_ptr) |-> ##2 ptr16_r == 16'($past(ptr16_r, 2) + 16'h0001))
    else $error("pointer increment wrong");
  pointer_load_a: assert property ( // [RULE5]
    take_op_s(op_load_ptr) |-> ##2 ptr16_r == $past(imm_word_in, 2))
    else $error("pointer load wrong");
  acc_minus_one_a: assert property ( // [RULE14]
    take_s(minus_one_op, src_acc) |-> ##2 acc_r == 8'($past(acc_r, 2) - 8'h01))
    else $error("accumulator decrement wrong");
  product_split_a: assert property ( // [RULE16]
    take_op_s(product_op) |-> ##2 {aux_r, acc_r} == $past(acc_r, 2) * $past(aux_r, 2))
    else $error("product split wrong");
  long_target_a: assert property ( // [RULE7]
    take_op_s(op_jmp_long) |-> ##2 target_valid_out && target_pc_out == $past(long_target_in, 2))
    else $error("long target wrong");
  page_target_a: assert property ( // [RULE8]
    take_op_s(op_jmp_page) |-> ##2 target_valid_out &&
      target_pc_out == {$past(next_pc_in[15:11], 2), $past(page_local_target_in, 2)})
    else $error("page target left the page");
  rel_target_a: assert property ( // [RULE9]
    take_op_s(op_jmp_rel) |-> ##2 target_pc_out ==
      16'($past(next_pc_in, 2) + {{8{$past(rel_offset_in[7], 2)}}, $past(rel_offset_in, 2)}))
    else $error("relative target wrong");
  bcd_digits_a: assert property ( // [RULE15]
    state_r == st_exec && op_r == bcd_adjust_op && acc_r[3:0] <= 4'h9 && acc_r[7:4] <= 4'h9 &&
      !psw_r[7] && !psw_r[6] |=> acc_r == $past(acc_r))
    else $error("decimal adjust changed valid digits");
  direct_ram_write_a: assert property ( // [RULE2]
    take_s(op_inc, src_direct) && !direct_addr_in[7] |-> ##3 ram_wr_en && !sfr_wr_out)
    else $error("direct RAM location not written back");
endmodule : aad_core

/* File: hdl/aad_ram.sv */
// lower internal RAM with registered read data
`timescale 1ns/1ps
module aad_ram #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 8
) (
  input  wire logic                     ref_clk_in,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]         rd_data_out,
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]         wr_data_in
);
  // starts cleared so reads before any write are defined; reset leaves it alone
  logic [WIDTH-1:0] mem_r [DEPTH] = '{default: '0};

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("aad_ram: unsupported size");
  end

  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) mem_r[wr_addr_in] <= wr_data_in;
  end

  // read-before-write: a same-address read returns the old word
  always_ff @(posedge ref_clk_in) begin
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule : aad_ram

/* File: shared/aad_map.svh */
// constants of the accumulator arithmetic datapath
// Operation
// RULE1 - register operand picks bank register zero..seven
// RULE2 - direct operand: lower 128 RAM or special register
// RULE3 - indirect address comes from register zero or one
// RULE4 - byte immediate supplies 8-bit source constant
// RULE5 - word immediate supplies 16-bit constant, loads pointer
// RULE6 - bit operand: 128 RAM flags or special-register flags
// RULE7 - long target is full 16-bit address
// RULE8 - page target keeps next instruction's 2K page
// RULE9 - relative jump adds signed offset to next address
// RULE10 - add writes source plus accumulator to accumulator
// RULE11 - add with carry includes carry flag
// RULE12 - subtract removes source and borrow from accumulator
// RULE13 - increment accumulator, register, direct, indirect, pointer
// RULE14 - decrement accumulator, register, direct or indirect
// RULE15 - decimal adjust leaves two packed BCD digits
// RULE16 - multiply/divide split results across accumulator and auxiliary
// RULE17 - add/subtract set flags; increment/decrement keep them
`ifndef AAD_MAP_SVH
`define AAD_MAP_SVH
`define AAD_SFR_ACC     8'he0
`define AAD_SFR_AUX     8'hf0
`define AAD_SFR_PSW     8'hd0
`define AAD_SFR_PTR_LO  8'h82
`define AAD_SFR_PTR_HI  8'h83
`define AAD_PSW_CY      7
`define AAD_PSW_AC      6
`define AAD_PSW_RS1     4
`define AAD_PSW_RS0     3
`define AAD_PSW_OV      2
`define AAD_PSW_P       0
`define AAD_RST_ACC     8'h00
`define AAD_RST_PSW     8'h00
`define AAD_RST_PTR     16'h0000
`define AAD_RST_PC      16'h0000
`define AAD_BIT_BASE    4'h2
`define AAD_BCD_LIMIT   4'h9
`define AAD_BCD_LO      9'h006
`define AAD_BCD_HI      9'h060
`define AAD_RAM_DEPTH   128
`endif

/* File: shared/aad_pkg.sv */
// types of the accumulator arithmetic datapath
package aad_pkg;
  typedef enum logic [3:0] {
    op_nop             = 4'h0,
    op_add             = 4'h1,
    sum_with_carry_op  = 4'h2,
    subtract_borrow_op = 4'h3,
    op_inc             = 4'h4,
    minus_one_op       = 4'h5,
    op_inc_ptr         = 4'h6,
    product_op         = 4'h7,
    op_quotient        = 4'h8,
    bcd_adjust_op      = 4'h9,
    op_load_ptr        = 4'ha,
    op_jmp_page        = 4'hb,
    op_jmp_long        = 4'hc,
    op_jmp_rel         = 4'hd,
    op_bit_read        = 4'he
  } aad_op_t;
  typedef enum logic [2:0] {
    src_none     = 3'h0,
    src_acc      = 3'h1,
    src_reg      = 3'h2,
    src_direct   = 3'h3,
    src_indirect = 3'h4,
    src_imm      = 3'h5
  } aad_src_t;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_ptr  = 3'b100,
    st_read = 3'b001,
    st_exec = 3'b011,
    st_wb   = 3'b010
  } aad_state_t;
endpackage : aad_pkg

/* File: verification/tb_accumulator_arith_datapath.sv */
// self-checking testbench of the accumulator arithmetic datapath
`timescale 1ns/1ps
module tb_accumulator_arith_datapath;
  import aad_pkg::*;
  logic        ref_clk_in;
  logic        nrst_in;
  logic        op_valid;
  aad_op_t     op_code;
  aad_src_t    src_mode;
  logic [2:0]  reg_sel;
  logic        ind_sel;
  logic [7:0]  dir_addr, imm_b, rel_off, sfr_rdata, sfr_addr, sfr_wdata, acc, aux, psw;
  logic [15:0] imm_w, next_pc, long_t, ptr, tgt_pc;
  logic [10:0] page_t;
  logic        ready, sfr_rd, sfr_wr, done, tgt_v, bit_v;
  logic [7:0]  rd_seen;
  int          n_errors;
  int          checked;

  aad_core dut (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .op_valid_in(op_valid), .ready_out(ready),
    .op_code_in(op_code), .src_mode_in(src_mode), .work_reg_sel_in(reg_sel),
    .pointer_reg_indirect_in(ind_sel), .direct_addr_in(dir_addr), .imm_byte_in(imm_b),
    .imm_word_in(imm_w), .next_pc_in(next_pc), .page_local_target_in(page_t),
    .long_target_in(long_t), .rel_offset_in(rel_off), .sfr_rd_out(sfr_rd),
    .sfr_wr_out(sfr_wr), .sfr_addr_out(sfr_addr), .sfr_wr_data_out(sfr_wdata),
    .sfr_rd_data_in(sfr_rdata), .done_out(done), .acc_out(acc), .aux_out(aux),
    .psw_out(psw), .sixteen_bit_pointer_out(ptr), .target_valid_out(tgt_v),
    .target_pc_out(tgt_pc), .bit_value_out(bit_v)
  );

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // read strobe is one cycle wide and combinational, so sample it mid-cycle
  always @(negedge ref_clk_in) begin
    if (sfr_rd === 1'b1) begin
      rd_seen = sfr_addr;
    end
  end

  task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check_val

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  // one operand field word feeds every field; pc also carries the outside register data
  task automatic do_op(input aad_op_t op, input aad_src_t src, input logic [15:0] arg,
                       input logic [15:0] pc, input int lat);
    int n;
    @(posedge ref_clk_in);
    op_code   <= op;
    src_mode  <= src;
    reg_sel   <= arg[2:0];
    ind_sel   <= arg[0];
    dir_addr  <= arg[7:0];
    imm_b     <= arg[7:0];
    rel_off   <= arg[7:0];
    imm_w     <= arg;
    long_t    <= arg;
    page_t    <= arg[10:0];
    next_pc   <= pc;
    sfr_rdata <= pc[7:0];
    op_valid  <= 1'b1;
    @(posedge ref_clk_in);
    op_valid <= 1'b0;
    n = 1;
    do begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20);
    check_val("done latency", 16'(lat), 16'(n));
  endtask : do_op

  task automatic t_alu;
    aad_op_t    ops[11] = '{op_add, op_add, bcd_adjust_op, op_add, sum_with_carry_op,
                            bcd_adjust_op, subtract_borrow_op, op_inc, minus_one_op,
                            subtract_borrow_op, sum_with_carry_op};
    logic [7:0] imm[11] = '{8'h49, 8'h38, 8'h00, 8'h79, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00,
                            8'h00, 8'h80};
    logic [7:0] res[11] = '{8'h49, 8'h81, 8'h87, 8'h00, 8'h01, 8'h01, 8'hff, 8'h00, 8'hff,
                            8'hfe, 8'h7e};
    logic [2:0] flg[11] = '{3'h0, 3'h3, 3'h3, 3'h6, 3'h0, 3'h0, 3'h6, 3'h6, 3'h6, 3'h0,
                            3'h5};
    aad_src_t   s;
    for (int i = 0; i < 11; i++) begin
      s = (ops[i] == op_inc || ops[i] == minus_one_op) ? src_acc : src_imm;
      do_op(ops[i], s, {8'h00, imm[i]}, 16'h0000, 2);
      check_val("acc", {8'h00, res[i]}, {8'h00, acc});
      check_val("flags", {13'h0, flg[i]}, {13'h0, psw[7], psw[6], psw[2]});
      check_val("parity", {15'h0, ^res[i]}, {15'h0, psw[0]});
    end
    $display("test alu done");
  endtask : t_alu

  task automatic t_muldiv;
    repeat (3) do_op(op_inc, src_direct, 16'h00f0, 16'h0000, 3);
    // a local register written back lands at the edge that ends the done cycle
    @(posedge ref_clk_in);
    #1;
    check_val("aux", 16'h0003, {8'h00, aux});
    do_op(product_op, src_none, 16'h0000, 16'h0000, 2);
    check_val("product", 16'h017a, {aux, acc});
    check_val("product flags", 16'h0001, {14'h0, psw[7], psw[2]});
    repeat (2) do_op(op_inc, src_direct, 16'h00f0, 16'h0000, 3);
    do_op(op_quotient, src_none, 16'h0000, 16'h0000, 2);
    check_val("quotient", 16'h0228, {aux, acc});
    repeat (2) do_op(minus_one_op, src_direct, 16'h00f0, 16'h0000, 3);
    @(posedge ref_clk_in);
    #1;
    check_val("aux", 16'h0000, {8'h00, aux});
    // divide by zero must leave both bytes alone and flag overflow
    do_op(op_quotient, src_none, 16'h0000, 16'h0000, 2);
    check_val("zero divide", 16'h0028, {aux, acc});
    check_val("zero divide flags", 16'h0001, {14'h0, psw[7], psw[2]});
    $display("test muldiv done");
  endtask : t_muldiv

  task automatic t_forms;
    do_op(op_bit_read, src_direct, 16'h00e3, 16'h0000, 3);
    check_val("bit e3", 16'h0001, {15'h0, bit_v});
    do_op(op_bit_read, src_direct, 16'h00e0, 16'h0000, 3);
    check_val("bit e0", 16'h0000, {15'h0, bit_v});
    do_op(op_inc, src_direct, 16'h0020, 16'h0000, 3);
    do_op(op_bit_read, src_direct, 16'h0000, 16'h0000, 3);
    check_val("bit ram flag", 16'h0001, {15'h0, bit_v});
    do_op(op_inc, src_reg, 16'h0007, 16'h0000, 3);
    check_val("reg inc keeps acc", 16'h0028, {8'h00, acc});
    do_op(op_add, src_reg, 16'h0007, 16'h0000, 3);
    check_val("reg source", 16'h0029, {8'h00, acc});
    do_op(minus_one_op, src_indirect, 16'h0001, 16'h0000, 4);
    check_val("indirect no sfr write", 16'h0000, {15'h0, sfr_wr});
    do_op(op_add, src_reg, 16'h0000, 16'h0000, 3);
    check_val("indirect target", 16'h0028, {8'h00, acc});
    $display("test forms done");
  endtask : t_forms

  task automatic t_sfr;
    rd_seen = 8'h00;
    do_op(op_add, src_direct, 16'h0090, 16'h0011, 3);
    check_val("sfr read addr", 16'h0090, {8'h00, rd_seen});
    check_val("acc", 16'h0039, {8'h00, acc});
    do_op(op_inc, src_direct, 16'h00a5, 16'h00ff, 3);
    check_val("sfr write", 16'h01a5, {7'h0, sfr_wr, sfr_addr});
    check_val("sfr data", 16'h0000, {8'h00, sfr_wdata});
    do_op(minus_one_op, src_direct, 16'h0098, 16'h0000, 3);
    check_val("sfr write", 16'h0198, {7'h0, sfr_wr, sfr_addr});
    check_val("sfr data", 16'h00ff, {8'h00, sfr_wdata});
    do_op(op_inc, src_direct, 16'h0030, 16'h0000, 3);
    check_val("ram no sfr write", 16'h0000, {15'h0, sfr_wr});
    $display("test sfr done");
  endtask : t_sfr

  task automatic t_ptr_jump;
    do_op(op_load_ptr, src_imm, 16'hfffe, 16'h0000, 2);
    check_val("pointer", 16'hfffe, ptr);
    do_op(op_inc_ptr, src_none, 16'h0000, 16'h0000, 2);
    check_val("pointer", 16'hffff, ptr);
    do_op(op_inc_ptr, src_none, 16'h0000, 16'h0000, 2);
    check_val("pointer wrap", 16'h0000, ptr);
    do_op(op_jmp_long, src_none, 16'hbeef, 16'h1234, 2);
    check_val("long target", 16'hbeef, tgt_pc);
    check_val("target valid", 16'h0001, {15'h0, tgt_v});
    // next instruction already in the following page: target follows it
    do_op(op_jmp_page, src_none, 16'h0123, 16'h5800, 2);
    check_val("page target", 16'h5923, tgt_pc);
    check_val("target valid", 16'h0001, {15'h0, tgt_v});
    do_op(op_jmp_rel, src_none, 16'h0080, 16'h1000, 2);
    check_val("rel target", 16'h0f80, tgt_pc);
    do_op(op_jmp_rel, src_none, 16'h007f, 16'hfff0, 2);
    check_val("rel target", 16'h006f, tgt_pc);
    $display("test ptr_jump done");
  endtask : t_ptr_jump

  initial begin
    n_errors = 0;
    checked = 0;
    nrst_in = 1'b0;
    op_valid = 1'b0;
    op_code = op_nop;
    src_mode = src_none;
    {reg_sel, ind_sel, dir_addr, imm_b, rel_off, sfr_rdata} = '0;
    {imm_w, next_pc, long_t, page_t} = '0;
    repeat (3) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    #1;
    check_val("reset regs", 16'h0000, {acc, aux} | ptr | tgt_pc | {8'h00, psw});
    check_val("reset ready", 16'h0001, {15'h0, ready});
    t_alu();
    t_muldiv();
    t_forms();
    t_sfr();
    t_ptr_jump();
    finish_test();
  end

  // about 40 operations of at most five cycles each
  initial begin
    repeat (3000) @(posedge ref_clk_in);
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end
endmodule : tb_accumulator_arith_datapath
